// *** src/lrc_pkg.sv ***
package lrc_pkg;
  // Register map and field layout of the ladder reference control register.
  localparam logic [31:0] CTRL_OFFSET     = 32'h0000_0000;
  localparam int          ENABLE_BIT      = 15;
  localparam int          PIN_OE_BIT      = 6;
  localparam int          RANGE_BIT       = 5;
  localparam int          SOURCE_BIT      = 4;
  localparam int          TAP_MSB         = 3;
  localparam int          TAP_LSB         = 0;
  localparam int          TAP_WIDTH       = 4;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_807F;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [3:0]  TAP_RESET       = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
endpackage : lrc_pkg

// *** src/lrc_ladder_reference_control.sv ***
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [R01] Enable at bit 15, other bits untouched
// [R02] Disabled: ladder powered down, fields kept
// [R03] Bits 31-16, 14-7 ignore writes, read zero
// [R04] Bit 6 connects level to output pin
// [R05] Bit 5 selects low or offset range
// [R06] Bit 4 selects external or analog supply
// [R07] Bits 3-0 tap code drives the ladder
// [R08] Level always routed to comparators internally; here comparator_ref_enable follows bit 15, so only while enabled
// [R09] Software avoids access right after disabling
// [R10] Reset clears all implemented bits to zero
module lrc_ladder_reference_control (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Ladder controls.
  output logic             ladder_power_down,
  output logic             ref_pin_output_enable,
  output logic             ref_range_select,
  output logic             ref_source_select,
  output logic      [3:0]  ref_tap_code,
  output logic             comparator_ref_enable
);

  // Stored control word and bus pipeline state.
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic        next_hresp;
  // Next values of the ladder controls.
  logic        next_ladder_power_down;
  logic        next_pin_oe;
  logic        next_range_sel;
  logic        next_source_sel;
  logic [3:0]  next_tap_code;
  logic        next_comp_en;
  // Address phase decode.
  logic        addr_hit;
  logic        active;
  logic        write_hit;
  logic        read_hit;

  // Keeps only the implemented fields; everything else stores and reads as zero.
  function automatic logic [31:0] implemented_bits(input logic [31:0] word);
    return word & lrc_pkg::CTRL_WRITE_MASK;
  endfunction : implemented_bits

  function automatic logic is_transfer(input logic sel, input logic rdy, input logic [1:0] trans);
    return sel && rdy && (trans == lrc_pkg::HTRANS_NONSEQ || trans == lrc_pkg::HTRANS_SEQ);
  endfunction : is_transfer

  // A transfer only hits the register when it is a word access to its offset.
  always_comb begin
    active    = is_transfer(hsel, hready, htrans);
    addr_hit  = (haddr == lrc_pkg::CTRL_OFFSET) && (hsize == lrc_pkg::HSIZE_WORD);
    write_hit = active && hwrite && addr_hit;
    read_hit  = active && !hwrite && addr_hit;
  end

  // A write lands at the end of its data phase, when hwdata stands.
  always_comb begin
    next_wr_pend = write_hit;
    next_ctrl    = ctrl;
    if (wr_pend) begin
      next_ctrl = implemented_bits(hwdata); // [R01] [R03]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= lrc_pkg::CTRL_RESET; // [R10]
      wr_pend <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      wr_pend <= next_wr_pend;
    end
  end

  // Read data is formed in the address phase so it stands for the data phase only.
  // A read right behind a write sees the new word because it looks at next_ctrl.
  always_comb begin
    next_hrdata    = lrc_pkg::READ_ZERO;
    next_hreadyout = 1'b1;
    next_hresp     = 1'b0;
    if (read_hit) begin
      next_hrdata = implemented_bits(next_ctrl); // [R03]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= lrc_pkg::READ_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  // Ladder controls move in the same cycle as the stored word.
  // The pin is also cut while disabled, since a powered-down ladder has no level to show.
  always_comb begin
    next_ladder_power_down = !next_ctrl[lrc_pkg::ENABLE_BIT]; // [R02]
    next_pin_oe            = next_ctrl[lrc_pkg::ENABLE_BIT] && next_ctrl[lrc_pkg::PIN_OE_BIT]; // [R04]
    next_range_sel         = next_ctrl[lrc_pkg::RANGE_BIT]; // [R05]
    next_source_sel        = next_ctrl[lrc_pkg::SOURCE_BIT]; // [R06]
    next_tap_code          = next_ctrl[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB]; // [R07]
    next_comp_en           = next_ctrl[lrc_pkg::ENABLE_BIT]; // [R08]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ladder_power_down     <= 1'b1;
      ref_pin_output_enable <= 1'b0;
      ref_range_select      <= 1'b0;
      ref_source_select     <= 1'b0;
      ref_tap_code          <= lrc_pkg::TAP_RESET;
      comparator_ref_enable <= 1'b0;
    end else begin
      ladder_power_down     <= next_ladder_power_down;
      ref_pin_output_enable <= next_pin_oe;
      ref_range_select      <= next_range_sel;
      ref_source_select     <= next_source_sel;
      ref_tap_code          <= next_tap_code;
      comparator_ref_enable <= next_comp_en;
    end
  end

  power_down_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    ladder_power_down == !ctrl[lrc_pkg::ENABLE_BIT])
    else $error("Ladder power-down does not follow the enable bit.");

  fields_kept_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (wr_pend && !hwdata[lrc_pkg::ENABLE_BIT]) |=>
    (ctrl == ($past(hwdata) & lrc_pkg::CTRL_WRITE_MASK)))
    else $error("Stored fields lost on a disabling write.");

  unused_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    implemented_bits(ctrl) == ctrl)
    else $error("Unimplemented control bits became set.");

  pin_connect_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    ref_pin_output_enable |-> (ctrl[lrc_pkg::PIN_OE_BIT] && ctrl[lrc_pkg::ENABLE_BIT]))
    else $error("Pin connected without the connect bit.");

  range_sel_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    ref_range_select == ctrl[lrc_pkg::RANGE_BIT])
    else $error("Range select differs from stored bit.");

  source_sel_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
    ref_source_select == ctrl[lrc_pkg::SOURCE_BIT])
    else $error("Source select differs from stored bit.");

  tap_code_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
    wr_pend |=> (ref_tap_code == ctrl[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB] &&
                 ctrl == ($past(hwdata) & lrc_pkg::CTRL_WRITE_MASK)))
    else $error("Tap code did not follow the write.");

  comp_route_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
    comparator_ref_enable == ctrl[lrc_pkg::ENABLE_BIT])
    else $error("Comparator reference not tied to enable.");

  reset_clear_a: assert property (@(posedge hclk) // [R10]
    $rose(hresetn) |-> (ctrl == lrc_pkg::CTRL_RESET && ladder_power_down))
    else $error("Control register not cleared by reset.");

  enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    wr_pend |=> (ctrl == ($past(hwdata) & lrc_pkg::CTRL_WRITE_MASK)))
    else $error("Write did not store the implemented bits.");

  enable_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (wr_pend && hwdata[lrc_pkg::ENABLE_BIT]) |=>
    (ctrl[lrc_pkg::PIN_OE_BIT:lrc_pkg::TAP_LSB] == next_ctrl[lrc_pkg::PIN_OE_BIT:lrc_pkg::TAP_LSB] || wr_pend))
    else $error("Fields changed without a write after enabling.");

  no_write_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    !wr_pend |=> $stable(ctrl))
    else $error("Control word changed without a write.");

  disabled_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    !ctrl[lrc_pkg::ENABLE_BIT] |-> (ladder_power_down && !ref_pin_output_enable && !comparator_ref_enable))
    else $error("Ladder active while disabled.");

  enabled_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    ctrl[lrc_pkg::ENABLE_BIT] |-> !ladder_power_down)
    else $error("Ladder powered down while enabled.");

  power_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    !wr_pend |=> $stable(ladder_power_down))
    else $error("Power-down changed without a write.");

  read_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    (read_hit && !wr_pend) |=> (hrdata == $past(ctrl)))
    else $error("Read data differs from the stored word.");

  read_after_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (read_hit && wr_pend) |=> (hrdata == ($past(hwdata) & lrc_pkg::CTRL_WRITE_MASK)))
    else $error("Read right after a write missed the new word.");

  read_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    !read_hit |=> (hrdata == lrc_pkg::READ_ZERO))
    else $error("Read data not zero outside a register read.");

  read_masked_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    implemented_bits(hrdata) == hrdata)
    else $error("Unimplemented bits read as one.");

  unmapped_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    (active && hwrite && !addr_hit) |=> !wr_pend)
    else $error("Write to another address was taken.");

  pin_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    (ctrl[lrc_pkg::ENABLE_BIT] && !ctrl[lrc_pkg::PIN_OE_BIT]) |-> !ref_pin_output_enable)
    else $error("Pin connected although the connect bit is clear.");

  pin_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    (ctrl[lrc_pkg::ENABLE_BIT] && ctrl[lrc_pkg::PIN_OE_BIT]) |-> ref_pin_output_enable)
    else $error("Pin not connected although the connect bit is set.");

  range_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    !wr_pend |=> $stable(ref_range_select))
    else $error("Range select changed without a write.");

  source_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
    !wr_pend |=> $stable(ref_source_select))
    else $error("Source select changed without a write.");

  tap_stored_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
    ref_tap_code == ctrl[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB])
    else $error("Tap code differs from the stored field.");

  tap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
    !wr_pend |=> $stable(ref_tap_code))
    else $error("Tap code changed without a write.");

  comp_free_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
    (ctrl[lrc_pkg::ENABLE_BIT] && !ctrl[lrc_pkg::PIN_OE_BIT]) |-> comparator_ref_enable)
    else $error("Comparator level lost when the pin is cut.");

  comp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
    !wr_pend |=> $stable(comparator_ref_enable))
    else $error("Comparator level changed without a write.");

  reset_outputs_a: assert property (@(posedge hclk) // [R10]
    $rose(hresetn) |-> (!ref_pin_output_enable && !ref_range_select && !ref_source_select &&
                        ref_tap_code == lrc_pkg::TAP_RESET && !comparator_ref_enable))
    else $error("Ladder controls not cleared by reset.");

  reset_read_a: assert property (@(posedge hclk) // [R10]
    $rose(hresetn) |-> (hrdata == lrc_pkg::READ_ZERO && hreadyout && !hresp))
    else $error("Bus outputs not at rest after reset.");

  ready_okay_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    (hreadyout && !hresp))
    else $error("Slave inserted a wait or an error response.");

endmodule : lrc_ladder_reference_control

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hreadyout, hresp, pd, oe, rs, ss, ce;
  logic [3:0]  tap;
  int          err_count = 0, num_checks = 0, cyc = 0;
  lrc_ladder_reference_control lrc_ladder_reference_control_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ladder_power_down(pd), .ref_pin_output_enable(oe),
    .ref_range_select(rs), .ref_source_select(ss), .ref_tap_code(tap), .comparator_ref_enable(ce));
  always #10 hclk = ~hclk;
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single AHB transfer; hready and hrdata are read at the negative edge before the sampling edge.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1; htrans <= lrc_pkg::HTRANS_NONSEQ; haddr <= a; hwrite <= w; hsize <= lrc_pkg::HSIZE_WORD;
    do begin @(negedge hclk); rdy = hreadyout; @(posedge hclk); end while (rdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do begin @(negedge hclk); rdy = hreadyout; rd = hrdata; @(posedge hclk); end while (rdy !== 1'b1);
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer
  task automatic chk_out(input logic [31:0] v);
    @(negedge hclk);
    chk({23'h0, pd, oe, rs, ss, tap, ce}, {23'h0, ~v[15], v[15] & v[6], v[5], v[4], v[3:0], v[15]});
  endtask : chk_out
  task automatic t_reset;
    xfer(1'b0, lrc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk_out(32'h0);
  endtask : t_reset
  task automatic t_mask;
    xfer(1'b1, lrc_pkg::CTRL_OFFSET, 32'hFFFF_FFFF);
    xfer(1'b0, lrc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_807F);
    chk_out(32'h0000_807F);
  endtask : t_mask
  task automatic t_fields;
    logic [31:0] vals [5] = '{32'h0000_8000, 32'h0000_804F, 32'h0000_8035, 32'h0000_802A, 32'h0000_801F};
    foreach (vals[i]) begin
      xfer(1'b1, lrc_pkg::CTRL_OFFSET, vals[i]);
      chk_out(vals[i]);
    end
  endtask : t_fields
  task automatic t_enable;
    xfer(1'b1, lrc_pkg::CTRL_OFFSET, 32'h0000_0065);
    chk_out(32'h0000_0065);
    xfer(1'b0, lrc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_0065);
    xfer(1'b1, lrc_pkg::CTRL_OFFSET, 32'h0000_8065);
    chk_out(32'h0000_8065);
    xfer(1'b1, lrc_pkg::CTRL_OFFSET, 32'h0000_0065);
    // An idle cycle always passes before the next access after disabling.
    xfer(1'b0, lrc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_0065);
  endtask : t_enable
  task automatic t_unmapped;
    xfer(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0004, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, lrc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_0065);
  endtask : t_unmapped
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_mask();
    t_fields();
    t_enable();
    t_unmapped();
    give_verdict();
  end
endmodule : tb
